//--- inc/write_strobe_n_port_regs.vh
// Purpose: Constants for the program/verify port of the on-chip EPROM.
// Assumes: 100 MHz system clock.
// Notes:   Times are in microseconds or milliseconds as printed.
`ifndef WRITE_STROBE_N_PORT_REGS_VH
`define WRITE_STROBE_N_PORT_REGS_VH
`define CLK_MHZ          100
`define ADDR_W           11
`define DATA_W           8
`define ERASED_BYTE      8'hff
`define T_WRITE_STROBE_N_MIN_MS    50
`define T_WRITE_STROBE_N_MAX_MS    60
`define T_AV_MAX_US      5
`define T_PD_MAX_US      5
`define T_PV_MAX_US      2
`define WRITE_STROBE_N_MIN_CYC     (`T_WRITE_STROBE_N_MIN_MS * 1000 * `CLK_MHZ)
`endif

//--- core/eprom_array.v
// Purpose: Byte-wide nonvolatile array model with an erased state.
// Assumes: One write port, one asynchronous read port.
// Notes:   Erased cells read all ones; writing clears the erased mark.
`include "write_strobe_n_port_regs.vh"
module eprom_array #(
    parameter AW = `ADDR_W,
    parameter DW = `DATA_W
) (
    input  wire          clk_sys,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr,
    output wire [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    reg          used [0:(1<<AW)-1];
    integer i;
    initial begin
        for (i = 0; i < (1<<AW); i = i + 1) begin
            used[i] = 1'b0;
            mem[i]  = {DW{1'b1}};
        end
    end
    always @(posedge clk_sys) begin
        if (we) begin
            mem[waddr]  <= wdata;
            used[waddr] <= 1'b1;
        end
    end
    // An untouched cell always answers all ones.
    assign rdata = used[raddr] ? mem[raddr] : `ERASED_BYTE;
endmodule // eprom_array

//--- core/eprom_program_verify_port.v
// Purpose: Program/verify port of the on-chip EPROM behind the general ports.
// Assumes: Programmer drives all inputs synchronously to clk_sys.
// Notes:   The array is written once per armed low strobe period, at its start.
`include "write_strobe_n_port_regs.vh"
module eprom_program_verify_port #(
    parameter AW = `ADDR_W,
    parameter DW = `DATA_W
) (
    input  wire          clk_sys,
    input  wire          rst,
    input  wire          programming_voltage,
    input  wire          verify_select,
    input  wire          write_strobe_n,
    input  wire [AW-1:0] write_strobe_n_addr,
    input  wire [DW-1:0] data_in_n,
    output reg  [DW-1:0] data_out,
    output reg           data_out_oe,
    output reg           write_strobe_n_mode,
    output reg           verify_mode
);
    localparam ST_IDLE   = 2'd0;
    localparam ST_VERIFY = 2'd1;
    localparam ST_WRITE_STROBE_N   = 2'd2;
    localparam ST_WAIT   = 2'd3;

    reg  [1:0]    state_r;
    reg  [1:0]    state_nxt;
    reg           strobe_armed_r;
    reg           we;
    wire [DW-1:0] rd_byte;
    wire [DW-1:0] true_byte;

    // The internal bus carries the inverted input port.
    assign true_byte = ~data_in_n;

    eprom_array #(.AW(AW), .DW(DW)) u_array (
        .clk_sys (clk_sys),
        .we      (we),
        .waddr   (write_strobe_n_addr),
        .wdata   (true_byte),
        .raddr   (write_strobe_n_addr),
        .rdata   (rd_byte)
    );

    // A strobe already low when the voltage arrives must not write; it must
    // first be seen high, which guards against a misordered power-up.
    always @(posedge clk_sys) begin
        if (rst || !programming_voltage) begin
            strobe_armed_r <= 1'b0;
        end else if (write_strobe_n) begin
            strobe_armed_r <= 1'b1;
        end
    end

    always @* begin
        state_nxt = state_r;
        we        = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (programming_voltage) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!programming_voltage) begin
                    state_nxt = ST_IDLE;
                end else if (strobe_armed_r && !write_strobe_n) begin
                    state_nxt = ST_WRITE_STROBE_N;
                    we        = 1'b1;
                end else if (write_strobe_n && verify_select) begin
                    state_nxt = ST_VERIFY;
                end
            end
            ST_VERIFY: begin
                if (!programming_voltage) begin
                    state_nxt = ST_IDLE;
                end else if (!write_strobe_n) begin
                    state_nxt = ST_WRITE_STROBE_N;
                    we        = 1'b1;
                end else if (!verify_select) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WRITE_STROBE_N: begin
                // Pulse length is timed by the programmer, not checked here.
                if (!programming_voltage) begin
                    state_nxt = ST_IDLE;
                end else if (write_strobe_n) begin
                    state_nxt = verify_select ? ST_VERIFY : ST_WAIT;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            state_r     <= ST_IDLE;
            data_out    <= `ERASED_BYTE;
            data_out_oe <= 1'b0;
            write_strobe_n_mode   <= 1'b0;
            verify_mode <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            write_strobe_n_mode   <= (state_nxt == ST_WRITE_STROBE_N);
            verify_mode <= (state_nxt == ST_VERIFY);
            data_out_oe <= (state_nxt == ST_WRITE_STROBE_N) || (state_nxt == ST_VERIFY);
            if (state_nxt == ST_WRITE_STROBE_N) begin
                // Only the bus value is shown; no pass/fail is reported.
                data_out <= true_byte;
            end else if (state_nxt == ST_VERIFY) begin
                // Read path uses only the address; the input port is ignored.
                data_out <= rd_byte;
            end else begin
                data_out <= `ERASED_BYTE;
            end
        end
    end
endmodule // eprom_program_verify_port

//--- testbench/port_checker.sv
// Purpose: pin checks. Assumes: one clock. Notes: stored bytes are judged by the bench.
module port_checker (
    input wire        clk_sys,
    input wire        rst,
    input wire        programming_voltage,
    input wire        verify_select,
    input wire        write_strobe_n,
    input wire [10:0] write_strobe_n_addr,
    input wire [7:0]  data_in_n,
    input wire [7:0]  data_out,
    input wire        data_out_oe,
    input wire        write_strobe_n_mode,
    input wire        verify_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence read_s; verify_mode && $stable(write_strobe_n_addr); endsequence
    mode_excl_a: assert property (!(write_strobe_n_mode && verify_mode)) else $error("modes");
    drop_idle_a: assert property (!programming_voltage |=> !data_out_oe) else $error("oe");
    read_drive_a: assert property (verify_mode |-> data_out_oe) else $error("read");
    select_gate_a: assert property (!verify_select |=> !verify_mode) else $error("sel");
    read_hold_a: assert property (read_s [*2] |-> $stable(data_out)) else $error("hold");
    burn_entry_a: assert property (programming_voltage && verify_mode && !write_strobe_n
        |=> write_strobe_n_mode) else $error("burn");
    burn_echo_a: assert property ($rose(write_strobe_n_mode) |-> data_out == ~$past(data_in_n))
        else $error("echo");
    verify_back_a: assert property (programming_voltage && write_strobe_n_mode && write_strobe_n
        && verify_select |=> verify_mode) else $error("back");
endmodule // port_checker
bind eprom_program_verify_port port_checker u_chk (.clk_sys(clk_sys), .rst(rst),
    .programming_voltage(programming_voltage), .verify_select(verify_select),
    .write_strobe_n(write_strobe_n), .write_strobe_n_addr(write_strobe_n_addr), .data_in_n(data_in_n),
    .data_out(data_out), .data_out_oe(data_out_oe), .write_strobe_n_mode(write_strobe_n_mode),
    .verify_mode(verify_mode));

//--- testbench/programmer_model.sv
// Purpose: programmer. Assumes: moves at falling edge. Notes: mode is {voltage,select,strobe}.
module programmer_model (
    input  wire        clk_sys,
    output reg         programming_voltage = 1'b0,
    output reg         verify_select = 1'b1,
    output reg         write_strobe_n = 1'b1,
    output reg  [10:0] write_strobe_n_addr = 11'h000,
    output reg  [7:0]  data_in_n = 8'hff
);
    timeunit 1ns;
    timeprecision 1ps;
    // Address and data settle one cycle before any strobe or mode change.
    task automatic put(input [2:0] m, input [10:0] a, input [7:0] d);
        @(negedge clk_sys);
        write_strobe_n_addr = a;
        data_in_n = ~d;
        @(negedge clk_sys);
        {programming_voltage, verify_select, write_strobe_n} = m;
    endtask
endmodule // programmer_model

//--- testbench/eprom_program_verify_port_tb.sv
// Purpose: bench. Assumes: 100 MHz. Notes: burn pulse cut to a few cycles, the port never times it.
module eprom_program_verify_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0, rst = 1'b1, hv, vs, sn, oe, pm, vm;
    logic [10:0] a;
    logic [7:0]  dn, q;
    int          error_cnt = 0, comparisons = 0, cyc = 0;
    eprom_program_verify_port u_dut (.clk_sys(clk_sys), .rst(rst), .programming_voltage(hv),
        .verify_select(vs), .write_strobe_n(sn), .write_strobe_n_addr(a), .data_in_n(dn), .data_out(q),
        .data_out_oe(oe), .write_strobe_n_mode(pm), .verify_mode(vm));
    programmer_model u_pgm (.clk_sys(clk_sys), .programming_voltage(hv), .verify_select(vs),
        .write_strobe_n(sn), .write_strobe_n_addr(a), .data_in_n(dn));
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 500) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input [7:0] g, input [7:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t %h %h", $time, g, e);
        end
    endtask
    task automatic go(input [2:0] m, input [10:0] ad, input [7:0] d);
        u_pgm.put(m, ad, d);
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic t_blank();
        go(3'b111, 11'h7ff, 8'h00);
        chk(q, 8'hff);
        chk({5'h0, oe, vm, pm}, 8'h06);
    endtask
    task automatic t_burn(input [10:0] ad, input [7:0] d);
        go(3'b110, ad, d);
        chk(q, d);
        go(3'b111, ad, d);
        chk(q, d);
        go(3'b111, ad, ~d);
        chk(q, d);
        go(3'b111, ad + 11'h001, d);
        chk(q, 8'hff);
    endtask
    task automatic t_refused();
        go(3'b101, 11'h055, 8'h00);
        chk({7'h0, vm}, 8'h00);
        go(3'b011, 11'h055, 8'h00);
        chk({7'h0, oe}, 8'h00);
        go(3'b010, 11'h055, 8'h00);
        go(3'b110, 11'h055, 8'h00);
        go(3'b111, 11'h055, 8'h00);
        chk(q, 8'hff);
    endtask
    initial begin
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        t_blank();
        t_burn(11'h123, 8'h5a);
        t_burn(11'h7fe, 8'h00);
        t_refused();
        complete_run();
    end
endmodule // eprom_program_verify_port_tb
